// ### shared/sma_pkg.sv
// Purpose: constants and carrier types for the status mask aggregator
// Assumes: 16-bit registers reached by plain index on an 8-bit address
// Notes: mask reserved fields are fixed at one

package sma_pkg;

  // ==========================================================
  // widths
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int CNT_W = 3;
  localparam int LOW_W = 9;
  localparam int EV_W = 3;

  // ==========================================================
  // register indices
  localparam logic [AW-1:0] GEN_MASK_OFS = 8'h1E;
  localparam logic [AW-1:0] MODEM_MASK_OFS = 8'h1F;
  localparam logic [AW-1:0] FAULT_STAT_OFS = 8'h20;
  localparam logic [AW-1:0] EVT_STAT_OFS = 8'h30;
  localparam logic [AW-1:0] EVT_CLR_OFS = 8'h31;
  localparam logic [AW-1:0] EVT_EN_OFS = 8'h32;

  // ==========================================================
  // reset values and writable fields
  localparam logic [DW-1:0] GEN_MASK_RST = 16'hFFFF;
  localparam logic [DW-1:0] MODEM_MASK_RST = 16'hFFFF;
  localparam logic [DW-1:0] FAULT_STAT_RST = 16'h0200;
  localparam logic [DW-1:0] GEN_MASK_WR = 16'h06CF;
  localparam logic [DW-1:0] MODEM_MASK_WR = 16'h1FFF;
  localparam logic [EV_W-1:0] EVT_EN_RST = 3'h0;

  // ==========================================================
  // fault summary word layout
  localparam int FS_GEN_SUM = 15;
  localparam int FS_MODEM_SUM = 14;
  localparam int FS_SELF_DIAG = 13;
  localparam int FS_OSC = 12;
  localparam int FS_CFG_PEND = 9;
  localparam logic [DW-1:0] ALARM_FEED = 16'h21FF;
  localparam logic [LOW_W-1:0] STICKY_DEF = 9'h1C0;

  // ==========================================================
  // event status bits
  localparam int EV_GEN = 0;
  localparam int EV_MODEM = 1;
  localparam int EV_ALARM = 2;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } sma_req_t;

endpackage

// ### hdl/sma_irq_agg.sv
// Purpose: event masks, fault summary word and interrupt aggregation
// Assumes: status inputs come from logic on I_CLOCK, no synchroniser
// Notes: read data valid only in the cycle after the read strobe
//
// Implementation choice: the strobed register port.

`timescale 1ns/100ps

module sma_irq_agg
  import sma_pkg::*;
#(
  parameter logic [LOW_W-1:0] STICKY_MASK = STICKY_DEF,
  parameter int CNT_BITS = CNT_W
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // register port
  input wire sma_req_t I_REQ,
  output logic [DW-1:0] O_RDATA,
  // status sources
  input wire logic [DW-1:0] I_GEN_STATUS,
  input wire logic [DW-1:0] I_MODEM_STATUS,
  input wire logic [DW-1:0] I_ALARM_MASK,
  input wire logic [LOW_W-1:0] I_ALARM_LOW,
  input wire logic I_SELF_DIAG_FAIL,
  input wire logic I_OSC_START_FAIL,
  input wire logic [CNT_W-1:0] I_CRC_COUNT,
  input wire logic I_CRC_LIMIT8,
  input wire logic I_CFG_LOADED,
  // summaries, interrupts and alarm
  output logic O_GEN_SUMMARY,
  output logic O_MODEM_SUMMARY,
  output logic O_ALARM_SUMMARY,
  output logic O_IRQ,
  output logic O_EVT_IRQ,
  output logic O_ALARM_N
);

  // ==========================================================
  // elaboration checks
  if (CNT_BITS != CNT_W) begin : g_cnt_chk
    $error("crc counter view needs a 3-bit counter");
  end

  // ==========================================================
  // decode
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] ofs);
    return a == ofs;
  endfunction

  logic wr_gen;
  logic wr_modem;
  logic wr_clr;
  logic wr_en;
  logic rd_fault;

  assign wr_gen = I_REQ.wr && hit(I_REQ.addr, GEN_MASK_OFS);
  assign wr_modem = I_REQ.wr && hit(I_REQ.addr, MODEM_MASK_OFS);
  assign wr_clr = I_REQ.wr && hit(I_REQ.addr, EVT_CLR_OFS);
  assign wr_en = I_REQ.wr && hit(I_REQ.addr, EVT_EN_OFS);
  assign rd_fault = I_REQ.rd && hit(I_REQ.addr, FAULT_STAT_OFS);

  // ==========================================================
  // mask registers
  logic [DW-1:0] gen_mask;
  logic [DW-1:0] modem_mask;

  // reserved fields forced to one so a stray write cannot unmask
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      gen_mask <= GEN_MASK_RST;
    end else if (wr_gen) begin
      gen_mask <= (I_REQ.wdata & GEN_MASK_WR) | ~GEN_MASK_WR;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      modem_mask <= MODEM_MASK_RST;
    end else if (wr_modem) begin
      modem_mask <= (I_REQ.wdata & MODEM_MASK_WR) | ~MODEM_MASK_WR;
    end
  end

  // ==========================================================
  // fault summary word
  logic [LOW_W-1:0] low_bits;
  logic self_diag;
  logic osc_fault;
  logic cfg_pending;
  logic [1:0] cnt_view;
  logic [DW-1:0] fault_word;

  // sticky bits keep a short pulse until software has seen it
  for (genvar i = 0; i < LOW_W; i++) begin : g_low
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        low_bits[i] <= 1'b0;
      end else if (STICKY_MASK[i]) begin
        // set wins over the clear by read
        low_bits[i] <= I_ALARM_LOW[i] | (low_bits[i] & ~rd_fault);
      end else begin
        low_bits[i] <= I_ALARM_LOW[i];
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      self_diag <= 1'b0;
      osc_fault <= 1'b0;
    end else begin
      self_diag <= I_SELF_DIAG_FAIL;
      osc_fault <= I_OSC_START_FAIL;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt_view <= 2'h0;
    end else if (I_CRC_LIMIT8) begin
      cnt_view <= I_CRC_COUNT[2:1];
    end else begin
      cnt_view <= I_CRC_COUNT[1:0];
    end
  end

  // never sets again: only a reset reopens the window
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cfg_pending <= FAULT_STAT_RST[FS_CFG_PEND];
    end else if (I_CFG_LOADED) begin
      cfg_pending <= 1'b0;
    end
  end

  assign fault_word = {O_GEN_SUMMARY, O_MODEM_SUMMARY, self_diag,
                       osc_fault, cnt_view, cfg_pending, low_bits};

  // ==========================================================
  // summaries and interrupt
  logic next_gen_sum;
  logic next_modem_sum;
  logic next_alarm_sum;
  logic next_alarm;

  // masked bits are ones in the mask words, so they drop out here
  assign next_gen_sum = |(I_GEN_STATUS & ~gen_mask);
  assign next_modem_sum = |(I_MODEM_STATUS & ~modem_mask);
  // bits 12 to 9 and the summaries are kept out of the irq path
  assign next_alarm_sum = |(fault_word & ~I_ALARM_MASK & ALARM_FEED);
  assign next_alarm = next_alarm_sum | cfg_pending
                    | (osc_fault & ~I_ALARM_MASK[FS_OSC]);

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_GEN_SUMMARY <= 1'b0;
      O_MODEM_SUMMARY <= 1'b0;
      O_ALARM_SUMMARY <= 1'b0;
      O_IRQ <= 1'b0;
      O_ALARM_N <= 1'b0;
    end else begin
      O_GEN_SUMMARY <= next_gen_sum;
      O_MODEM_SUMMARY <= next_modem_sum;
      O_ALARM_SUMMARY <= next_alarm_sum;
      O_IRQ <= next_gen_sum | next_modem_sum | next_alarm_sum;
      O_ALARM_N <= ~next_alarm;
    end
  end

  // ==========================================================
  // event status, clear and enable
  logic [EV_W-1:0] evt_stat;
  logic [EV_W-1:0] evt_en;
  logic [EV_W-1:0] evt_set;

  assign evt_set[EV_GEN] = next_gen_sum & ~O_GEN_SUMMARY;
  assign evt_set[EV_MODEM] = next_modem_sum & ~O_MODEM_SUMMARY;
  assign evt_set[EV_ALARM] = next_alarm_sum & ~O_ALARM_SUMMARY;

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      evt_stat <= '0;
    end else if (wr_clr) begin
      evt_stat <= (evt_stat & ~I_REQ.wdata[EV_W-1:0]) | evt_set;
    end else begin
      evt_stat <= evt_stat | evt_set;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      evt_en <= EVT_EN_RST;
    end else if (wr_en) begin
      evt_en <= I_REQ.wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_EVT_IRQ <= 1'b0;
    end else begin
      O_EVT_IRQ <= |(evt_stat & evt_en);
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= '0;
    end else if (!I_REQ.rd) begin
      O_RDATA <= '0;
    end else begin
      case (I_REQ.addr)
        GEN_MASK_OFS: O_RDATA <= gen_mask;
        MODEM_MASK_OFS: O_RDATA <= modem_mask;
        FAULT_STAT_OFS: O_RDATA <= fault_word;
        EVT_STAT_OFS: O_RDATA <= {{(DW-EV_W){1'b0}}, evt_stat};
        EVT_EN_OFS: O_RDATA <= {{(DW-EV_W){1'b0}}, evt_en};
        default: O_RDATA <= '0;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESETN);

  sequence sticky_read;
    rd_fault && ((I_ALARM_LOW & STICKY_MASK) == '0);
  endsequence

  sequence sticky_quiet;
    !rd_fault && ((I_ALARM_LOW & STICKY_MASK) == '0);
  endsequence

  gen_summary_a: assert property (
    |(I_GEN_STATUS & ~gen_mask) |=> O_GEN_SUMMARY
  ) else $error("general summary missed an unmasked bit");

  gen_masked_a: assert property (
    (I_GEN_STATUS & ~gen_mask) == '0 |=> !O_GEN_SUMMARY
  ) else $error("masked general event raised summary");

  modem_summary_a: assert property (
    |(I_MODEM_STATUS & ~modem_mask) |=> O_MODEM_SUMMARY ##0
    O_IRQ
  ) else $error("modem summary or irq missed");

  reserved_ones_a: assert property (
    ((gen_mask | GEN_MASK_WR) == 16'hFFFF)
    && ((modem_mask | MODEM_MASK_WR) == 16'hFFFF)
  ) else $error("reserved mask field not one");

  modem_write_a: assert property (
    wr_modem |=> modem_mask[12:0] == $past(I_REQ.wdata[12:0])
  ) else $error("modem mask write lost");

  irq_or_a: assert property (
    O_IRQ == (O_GEN_SUMMARY | O_MODEM_SUMMARY | O_ALARM_SUMMARY)
  ) else $error("irq differs from summary or");

  osc_alarm_a: assert property (
    osc_fault && !I_ALARM_MASK[FS_OSC] |=> !O_ALARM_N
  ) else $error("oscillator fault did not assert alarm");

  cfg_hold_a: assert property (
    cfg_pending |=> !O_ALARM_N ##0 ($past(I_CFG_LOADED) || cfg_pending)
  ) else $error("pending config did not hold alarm");

  cfg_final_a: assert property (
    !cfg_pending |=> !cfg_pending
  ) else $error("config pending set again");

  crc_view_a: assert property (
    I_CRC_LIMIT8 |=> cnt_view == $past(I_CRC_COUNT[2:1])
  ) else $error("crc view wrong for limit eight");

  sticky_clear_a: assert property (
    sticky_read |=> (low_bits & STICKY_MASK) == '0
  ) else $error("sticky fault not cleared by read");

  sticky_hold_a: assert property (
    sticky_quiet |=> (low_bits & STICKY_MASK)
    == ($past(low_bits) & STICKY_MASK)
  ) else $error("sticky fault lost without read");

  read_data_a: assert property (
    rd_fault |=> O_RDATA == $past(fault_word)
  ) else $error("fault word read wrong");

  read_idle_a: assert property (
    !I_REQ.rd |=> O_RDATA == '0
  ) else $error("read data stood beyond one cycle");

  modem_masked_a: assert property (
    (I_MODEM_STATUS & ~modem_mask) == '0 |=> !O_MODEM_SUMMARY
  ) else $error("masked modem event raised summary");

  alarm_masked_a: assert property (
    (fault_word & ~I_ALARM_MASK & ALARM_FEED) == '0 |=> !O_ALARM_SUMMARY
  ) else $error("masked fault raised alarm summary");

  gen_write_a: assert property (
    wr_gen |=> gen_mask == ($past(I_REQ.wdata) | ~GEN_MASK_WR)
  ) else $error("general mask write wrong");

  cfg_clear_a: assert property (
    I_CFG_LOADED |=> !cfg_pending
  ) else $error("config pending not cleared by load");

  diag_follow_a: assert property (
    I_RESETN |=> fault_word[FS_SELF_DIAG] == $past(I_SELF_DIAG_FAIL)
  ) else $error("self diagnostic bit lags its input");

  crc_low_a: assert property (
    I_RESETN && !I_CRC_LIMIT8 |=> cnt_view == $past(I_CRC_COUNT[1:0])
  ) else $error("crc view wrong for small limit");

endmodule // sma_irq_agg

// ### verification/sma_host_model.sv
// Purpose: host side model that drives the register port
// Assumes: one access per call, strobes one cycle long
// Notes: the port returns to all zero between accesses
`timescale 1ns/100ps

module sma_host_model
  import sma_pkg::*;
(
  // clock
  input wire logic i_clk,
  // register port
  output sma_req_t o_req,
  input wire logic [DW-1:0] i_rdata
);
  initial o_req = '0;

  task automatic write(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    o_req <= '0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic read(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge i_clk);
    o_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    o_req <= '0;
    #1 d = i_rdata;
  endtask
endmodule // sma_host_model

// ### verification/status_mask_irq_aggregator_tb.sv
// Purpose: self-checking bench for the status mask aggregator
// Assumes: status sources driven by the bench on the same clock
// Notes: masks with all writable bits at zero read back F930 / E000
`timescale 1ns/100ps

module status_mask_irq_aggregator_tb;
  import sma_pkg::*;
  // ===========================================================
  // signals
  logic clk = 0, rst_n = 0;
  wire sma_req_t req;
  logic [DW-1:0] rdata, gs = 0, ms = 0, am = 16'hFFFF;
  logic [LOW_W-1:0] al = 0;
  logic sd = 0, osc = 0, l8 = 0, cl = 0;
  logic [CNT_W-1:0] cc = 0;
  logic gsum, msum, asum, irq, eirq, alarm_n;
  int num_errors = 0, checks_done = 0, cyc = 0;

  initial forever #4 clk = ~clk;

  sma_host_model h (.i_clk(clk), .o_req(req), .i_rdata(rdata));

  sma_irq_agg dut (
    .I_CLOCK(clk), .I_RESETN(rst_n), .I_REQ(req), .O_RDATA(rdata),
    .I_GEN_STATUS(gs), .I_MODEM_STATUS(ms), .I_ALARM_MASK(am),
    .I_ALARM_LOW(al), .I_SELF_DIAG_FAIL(sd), .I_OSC_START_FAIL(osc),
    .I_CRC_COUNT(cc), .I_CRC_LIMIT8(l8), .I_CFG_LOADED(cl),
    .O_GEN_SUMMARY(gsum), .O_MODEM_SUMMARY(msum),
    .O_ALARM_SUMMARY(asum), .O_IRQ(irq), .O_EVT_IRQ(eirq),
    .O_ALARM_N(alarm_n)
  );

  // ===========================================================
  // helpers
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    h.read(a, d);
    chk(d, exp);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // a hang is cut short well above the fewer than two hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  // ===========================================================
  // tests
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    rchk(GEN_MASK_OFS, 16'hFFFF);
    rchk(MODEM_MASK_OFS, 16'hFFFF);
    rchk(FAULT_STAT_OFS, 16'h0200);
    chk(alarm_n, 1'b0);
    h.write(FAULT_STAT_OFS, 16'hFFFF);
    rchk(FAULT_STAT_OFS, 16'h0200);
    rchk(8'h40, 16'h0000);
    $display("test 1 done");
    h.write(GEN_MASK_OFS, 16'h0000);
    h.write(MODEM_MASK_OFS, 16'h0000);
    rchk(GEN_MASK_OFS, 16'hF930);
    rchk(MODEM_MASK_OFS, 16'hE000);
    // one status bit at a time against the cleared masks
    for (int i = 0; i < DW; i++) begin
      @(posedge clk);
      gs <= 16'h0001 << i;
      ms <= 16'h0000;
      wait_n(1);
      chk(gsum, !(16'hF930 >> i & 1));
      chk(irq, !(16'hF930 >> i & 1));
      @(posedge clk);
      gs <= 0;
      ms <= 16'h0001 << i;
      wait_n(1);
      chk(msum, !(16'hE000 >> i & 1));
      chk(irq, !(16'hE000 >> i & 1));
    end
    @(posedge clk);
    gs <= 16'h0040;
    ms <= 16'h0001;
    wait_n(1);
    rchk(FAULT_STAT_OFS, 16'hC200);
    @(posedge clk);
    gs <= 0;
    ms <= 0;
    $display("test 2 done");
    rchk(EVT_STAT_OFS, 16'h0003);
    h.write(EVT_EN_OFS, 16'h0001);
    wait_n(1);
    chk(eirq, 1'b1);
    h.write(EVT_CLR_OFS, 16'h0003);
    rchk(EVT_STAT_OFS, 16'h0000);
    chk(eirq, 1'b0);
    rchk(EVT_EN_OFS, 16'h0001);
    rchk(EVT_CLR_OFS, 16'h0000);
    $display("test 3 done");
    @(posedge clk);
    sd <= 1;
    osc <= 1;
    cc <= 3'h6;
    l8 <= 1;
    cl <= 1;
    @(posedge clk);
    cl <= 0;
    wait_n(3);
    rchk(FAULT_STAT_OFS, 16'h3C00);
    chk(alarm_n, 1'b1);
    @(posedge clk);
    l8 <= 0;
    am <= 0;
    wait_n(3);
    rchk(FAULT_STAT_OFS, 16'h3800);
    chk(asum, 1'b1);
    chk(irq, 1'b1);
    chk(alarm_n, 1'b0);
    @(posedge clk);
    sd <= 0;
    wait_n(3);
    chk(asum, 1'b0);
    chk(irq, 1'b0);
    chk(alarm_n, 1'b0);
    $display("test 4 done");
    @(posedge clk);
    al <= 9'h080;
    @(posedge clk);
    al <= 0;
    wait_n(3);
    chk(asum, 1'b1);
    rchk(FAULT_STAT_OFS, 16'h1880);
    rchk(FAULT_STAT_OFS, 16'h1800);
    wait_n(3);
    chk(asum, 1'b0);
    @(posedge clk);
    al <= 9'h100;
    wait_n(3);
    rchk(FAULT_STAT_OFS, 16'h1900);
    @(posedge clk);
    al <= 0;
    rchk(FAULT_STAT_OFS, 16'h1900);
    rchk(FAULT_STAT_OFS, 16'h1800);
    $display("test 5 done");
    finish_test();
  end
endmodule // status_mask_irq_aggregator_tb
